/* File: ddrp_pkg.sv */
package ddrp_pkg;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;  // path modes and bypasses
    localparam logic [7:0] DELAY_OFS  = 8'h04;  // delay chain settings
    localparam logic [7:0] STATUS_OFS = 8'h08;  // read-only path state

    // reset values of the software registers (all bits low at power up)
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] DELAY_RST = 32'h0000_0000;

    // control field positions
    localparam int CAP_BYP_BIT   = 0;   // bypass double-rate capture
    localparam int RSY_BYP_BIT   = 1;   // bypass input resync levels
    localparam int HALF_BYP_BIT  = 2;   // bypass input half-rate stage
    localparam int SEP_CLK_BIT   = 3;   // separate strobe / echo capture
    localparam int CAP_SEL_LSB   = 4;   // capture clock source, 2 bits
    localparam int RSY_LVL_LSB   = 6;   // resync levels used, 2 bits
    localparam int DOUT_BYP_BIT  = 8;   // direct input instead of half-rate
    localparam int OREG_BYP_BIT  = 9;   // bypass final core output register
    localparam int OHALF_BYP_BIT = 10;  // bypass output half-rate stage
    localparam int ORSY_BYP_BIT  = 11;  // bypass output resync register
    localparam int OE_BYP_BIT    = 12;  // bypass final output-enable register
    localparam int SDR_BIT       = 13;  // single data rate output
    localparam int SDR_REG_BIT   = 14;  // registered sdr output
    localparam int LVL_MODE_BIT  = 15;  // write-leveling registers in use
    localparam int WCLK_SRC_BIT  = 16;  // write clocks from leveling chain
    localparam int CHAIN_BIT     = 17;  // divider follows chain input
    localparam int STB_INV_BIT   = 18;  // invert capture strobe

    // capture clock sources
    typedef enum logic [1:0] {
        DDRP_CAP_GATED  = 2'b00,  // strobe with postamble gating
        DDRP_CAP_STROBE = 2'b01,  // strobe without gating
        DDRP_CAP_GLOBAL = 2'b10   // global clock line
    } ddrp_cap_type;

    // delay chains: out x2, in x1, oe x2, term x2, strobe in, strobe bus
    localparam int NUM_CHAINS = 9;
    localparam int DLY_BITS   = 3;   // setting width per chain
    localparam int DLY_MAX    = 7;   // deepest tap in cycles

    // captured double-rate sample pair
    typedef struct packed {
        logic rise;  // taken on rising strobe edge
        logic fall;  // taken on falling / echo edge
    } ddrp_pair_type;

    // apb slave answer
    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } ddrp_apb_rsp_type;

endpackage

/* File: ddrp_io_datapath.sv */
// Notes on behaviour
// - input capture, resync, half-rate stages each bypassable
// - capture has rise, fall and align registers
// - capture shares one clock or strobe/echo pair
// - align register uses the rising capture clock
// - up to three resync levels into system
// - resync data direct or into half-rate registers
// - run-time select: direct or half-rate to core
// - output-register bypass picks mux or fourth register
// - divider serves one group, chains for wider
// - output and enable stages each bypassable
// - half-rate core data converted to full rate
// - sdr combinatorial/registered or ddr full/half rate
// - resync and leveling both on system clock
// - leveling registers only in ddr3 mode
// - data and strobe write clocks 90 degrees apart
// - enable path mirrors output path latency except in combinatorial sdr, plus oe register unless bypassed
// - nine per-pin delay chains in set counts
// - delay settings writable at run time
// - strobe input and strobe bus out delay chains
// - capture clock from gated/ungated strobe or global
// - settings power up with all bits low
`timescale 1ns/1ns
`default_nettype none

module ddrp_io_datapath #(
    parameter int HALF_W = 4  // half-rate word width (two full-rate pairs)
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              pad_in,
    input  wire logic              strobe_in,
    input  wire logic              echo_in,
    input  wire logic              global_clk_in,
    input  wire logic              postamble_en,
    input  wire logic              chain_in,
    output logic                   chain_out,
    output logic [HALF_W-1:0]      core_rd_data,
    input  wire logic [HALF_W-1:0] core_wr_data,
    input  wire logic [1:0]        core_oe,
    input  wire logic              core_term_en,
    output logic [1:0]             pad_out,
    output logic                   pad_oe,
    output logic                   pad_term_en,
    output logic                   strobe_bus_out,
    output logic                   wclk_dq,
    output logic                   wclk_dqs
);

    // software registers
    logic [31:0]                ctrl_r;       // mode and bypass bits
    logic [31:0]                delay_r;      // delay chain settings
    ddrp_pkg::ddrp_apb_rsp_type apb_r;        // registered bus answer
    logic                       map_hit;      // address decodes
    logic [31:0]                rd_mux;       // read data select
    logic [31:0]                status;       // live state view

    // input path state
    logic                       stb_lvl;      // selected capture strobe level
    logic                       stb_d_r;      // previous strobe level
    logic                       echo_d_r;     // previous echo level
    logic                       rise_ev;      // rising capture edge
    logic                       fall_ev;      // falling capture edge
    logic                       din_dly;      // pad after input delay
    ddrp_pkg::ddrp_pair_type    pos_r;        // rise and fall capture hold
    ddrp_pkg::ddrp_pair_type    align_r;      // aligned pair
    ddrp_pkg::ddrp_pair_type    cap_out;      // capture stage output
    ddrp_pkg::ddrp_pair_type    rsy_r [3];    // resync levels
    ddrp_pkg::ddrp_pair_type    rsy_out;      // resync stage output
    logic [HALF_W-1:0]          half_r;       // half-rate collect
    logic [HALF_W-1:0]          half_out;     // half-rate stage output
    logic [HALF_W-1:0]          mux2;         // second mux toward core
    logic [HALF_W-1:0]          align4_r;     // fourth alignment register
    logic                       div_r;        // local io clock divider
    logic                       div_ph;       // divider phase in use

    // output path state
    ddrp_pkg::ddrp_pair_type    ofull;        // full-rate from half-rate
    ddrp_pkg::ddrp_pair_type    ohalf_r;      // half-rate stage register
    ddrp_pkg::ddrp_pair_type    ohalf_out;    // half-rate stage output
    ddrp_pkg::ddrp_pair_type    orsy_r;       // output resync register
    ddrp_pkg::ddrp_pair_type    orsy_out;     // output resync output
    ddrp_pkg::ddrp_pair_type    olvl_r;       // write-leveling register
    ddrp_pkg::ddrp_pair_type    olvl_out;     // leveling stage output
    logic                       oe_full;      // enable at full rate
    logic                       oe_half_r;    // enable half-rate register
    logic                       oe_half_out;  // enable half-rate output
    logic                       oe_rsy_r;     // enable resync register
    logic                       oe_rsy_out;   // enable resync output
    logic                       oe_lvl_r;     // enable leveling register
    logic                       oe_lvl_out;   // enable leveling output
    logic                       oe_reg_r;     // output-enable register
    logic                       oe_fin;       // enable before delay
    logic [1:0]                 wph_r;        // write clock phase counter

    // delay chains
    logic [ddrp_pkg::NUM_CHAINS-1:0]  dly_in;   // chain inputs
    logic [ddrp_pkg::NUM_CHAINS-1:0]  dly_out;  // chain outputs
    logic [1:0]                       pout_pre; // pad pair before delay

    // apb decode and read mux
    always_comb begin
        map_hit = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            ddrp_pkg::CTRL_OFS:   rd_mux = ctrl_r;
            ddrp_pkg::DELAY_OFS:  rd_mux = delay_r;
            ddrp_pkg::STATUS_OFS: rd_mux = status;
            default:              map_hit = 1'b0;  // unmapped: error
        endcase
    end

    // status: capture pair, align pair, divider, write clock phase and oe state
    assign status = {24'h00_0000, oe_reg_r, wph_r, div_r,
                     align_r.rise, align_r.fall, pos_r.rise, pos_r.fall};

    // apb answer: one wait cycle, ready registered
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            apb_r <= '0;
        end else if (psel && penable && !apb_r.ready) begin
            apb_r.ready <= 1'b1;
            apb_r.err   <= ~map_hit;
            apb_r.rdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            apb_r <= '0;
        end
    end

    assign pready  = apb_r.ready;
    assign pslverr = apb_r.err;
    assign prdata  = apb_r.rdata;

    // register writes at completing edge; run-time changes allowed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r  <= ddrp_pkg::CTRL_RST;
            delay_r <= ddrp_pkg::DELAY_RST;
        end else if (psel && penable && apb_r.ready && pwrite && map_hit) begin
            if (paddr == ddrp_pkg::CTRL_OFS) begin
                ctrl_r <= pwdata;
            end
            if (paddr == ddrp_pkg::DELAY_OFS) begin
                delay_r <= pwdata;
            end
        end
    end

    // capture clock source select with optional inversion
    always_comb begin
        case (ddrp_pkg::ddrp_cap_type'(ctrl_r[ddrp_pkg::CAP_SEL_LSB +: 2]))
            ddrp_pkg::DDRP_CAP_GATED:  stb_lvl = dly_out[7] & postamble_en;
            ddrp_pkg::DDRP_CAP_STROBE: stb_lvl = dly_out[7];
            ddrp_pkg::DDRP_CAP_GLOBAL: stb_lvl = global_clk_in;
            default:                   stb_lvl = global_clk_in;
        endcase
        stb_lvl = stb_lvl ^ ctrl_r[ddrp_pkg::STB_INV_BIT];
    end

    // capture edges: shared clock or strobe rise plus echo rise
    assign rise_ev = stb_lvl & ~stb_d_r;
    assign fall_ev = ctrl_r[ddrp_pkg::SEP_CLK_BIT] ? (echo_in & ~echo_d_r)
                                                   : (~stb_lvl & stb_d_r);

    // strobe history for edge detection
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stb_d_r  <= 1'b0;
            echo_d_r <= 1'b0;
        end else begin
            stb_d_r  <= stb_lvl;
            echo_d_r <= echo_in;
        end
    end

    // double-rate capture: rise reg, fall reg, align on rise clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pos_r   <= '0;
            align_r <= '0;
        end else begin
            if (rise_ev) begin
                pos_r.rise <= din_dly;
                align_r    <= pos_r;
            end
            if (fall_ev) begin
                pos_r.fall <= din_dly;
            end
        end
    end

    // capture stage bypass passes pad straight through
    assign cap_out = ctrl_r[ddrp_pkg::CAP_BYP_BIT] ? {din_dly, din_dly}
                                                   : align_r;

    // resync levels into the system domain
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rsy_r[0] <= '0;
            rsy_r[1] <= '0;
            rsy_r[2] <= '0;
        end else begin
            rsy_r[0] <= cap_out;
            rsy_r[1] <= rsy_r[0];
            rsy_r[2] <= rsy_r[1];
        end
    end

    // level count: 0 means bypass, 1..3 taps the chain
    always_comb begin
        if (ctrl_r[ddrp_pkg::RSY_BYP_BIT]) begin
            rsy_out = cap_out;
        end else begin
            case (ctrl_r[ddrp_pkg::RSY_LVL_LSB +: 2])
                2'h0:    rsy_out = cap_out;
                2'h1:    rsy_out = rsy_r[0];
                2'h2:    rsy_out = rsy_r[1];
                2'h3:    rsy_out = rsy_r[2];
                default: rsy_out = rsy_r[2];
            endcase
        end
    end

    // io clock divider; chained followers take neighbour phase
    assign div_ph = ctrl_r[ddrp_pkg::CHAIN_BIT] ? chain_in : div_r;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_r     <= 1'b0;
            chain_out <= 1'b0;
        end else begin
            div_r     <= ~div_ph;
            chain_out <= ~div_ph;
        end
    end

    // half-rate conversion on divided clock phase
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            half_r <= '0;
        end else if (div_ph) begin
            half_r[3:2] <= rsy_out;
        end else begin
            half_r[1:0] <= rsy_out;
        end
    end

    assign half_out = ctrl_r[ddrp_pkg::HALF_BYP_BIT] ? {rsy_out, rsy_out}
                                                     : half_r;

    // second mux: direct input or half-rate word
    assign mux2 = ctrl_r[ddrp_pkg::DOUT_BYP_BIT] ? {rsy_out, rsy_out}
                                                 : half_out;

    // fourth alignment register and final core output select
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            align4_r     <= '0;
            core_rd_data <= '0;
        end else begin
            align4_r     <= mux2;
            core_rd_data <= ctrl_r[ddrp_pkg::OREG_BYP_BIT] ? mux2 : align4_r;
        end
    end

    // output path: half-rate word to full-rate pair by divider phase
    assign ofull = div_ph ? core_wr_data[3:2] : core_wr_data[1:0];
    assign oe_full = div_ph ? core_oe[1] : core_oe[0];

    // output half-rate, resync and leveling registers with enable mirror
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ohalf_r   <= '0;
            orsy_r    <= '0;
            olvl_r    <= '0;
            oe_half_r <= 1'b0;
            oe_rsy_r  <= 1'b0;
            oe_lvl_r  <= 1'b0;
            oe_reg_r  <= 1'b0;
        end else begin
            ohalf_r   <= ofull;
            orsy_r    <= ohalf_out;
            olvl_r    <= orsy_out;
            oe_half_r <= oe_full;
            oe_rsy_r  <= oe_half_out;
            oe_lvl_r  <= oe_rsy_out;
            oe_reg_r  <= oe_lvl_out;
        end
    end

    // per-stage bypasses; same bits steer data and enable, except OE_BYP_BIT which steers only the enable
    assign ohalf_out   = ctrl_r[ddrp_pkg::OHALF_BYP_BIT] ? ofull : ohalf_r;
    assign oe_half_out = ctrl_r[ddrp_pkg::OHALF_BYP_BIT] ? oe_full : oe_half_r;
    assign orsy_out    = ctrl_r[ddrp_pkg::ORSY_BYP_BIT] ? ohalf_out : orsy_r;
    assign oe_rsy_out  = ctrl_r[ddrp_pkg::ORSY_BYP_BIT] ? oe_half_out : oe_rsy_r;
    assign olvl_out    = ctrl_r[ddrp_pkg::LVL_MODE_BIT] ? olvl_r : orsy_out;
    assign oe_lvl_out  = ctrl_r[ddrp_pkg::LVL_MODE_BIT] ? oe_lvl_r : oe_rsy_out;
    assign oe_fin      = ctrl_r[ddrp_pkg::OE_BYP_BIT] ? oe_lvl_out : oe_reg_r;

    // sdr: both halves carry registered rise bit or raw core_wr_data[0]; else ddr pair
    always_comb begin
        if (!ctrl_r[ddrp_pkg::SDR_BIT]) begin
            pout_pre = olvl_out;
        end else if (ctrl_r[ddrp_pkg::SDR_REG_BIT]) begin
            pout_pre = {olvl_out.rise, olvl_out.rise};
        end else begin
            pout_pre = {core_wr_data[0], core_wr_data[0]};
        end
    end

    // delay chain inputs: out x2 series, in, oe x2, term x2, strobe x2
    assign dly_in[0] = pout_pre[1];
    assign dly_in[1] = dly_out[0];
    assign dly_in[2] = pad_in;
    assign dly_in[3] = oe_fin;
    assign dly_in[4] = dly_out[3];
    assign dly_in[5] = core_term_en;
    assign dly_in[6] = dly_out[5];
    assign dly_in[7] = strobe_in;
    assign dly_in[8] = dly_out[7];
    assign din_dly   = dly_out[2];

    // one tapped delay line per chain, setting from delay register
    generate
        for (genvar c = 0; c < ddrp_pkg::NUM_CHAINS; c++) begin : g_dly
            logic [ddrp_pkg::DLY_MAX-1:0] line_r;   // tap history
            logic [ddrp_pkg::DLY_BITS-1:0] sel;     // chosen tap
            assign sel = delay_r[c*ddrp_pkg::DLY_BITS +: ddrp_pkg::DLY_BITS];
            // shift the chain input down the line
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    line_r <= '0;
                end else begin
                    line_r <= {line_r[ddrp_pkg::DLY_MAX-2:0], dly_in[c]};
                end
            end
            // setting zero is no delay, n is n cycles
            assign dly_out[c] = (sel == 3'h0) ? dly_in[c] : line_r[sel - 3'h1];
        end
    endgenerate

    // pad side registers; only the rise half of the output pair is delayed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pad_out        <= 2'h0;
            pad_oe         <= 1'b0;
            pad_term_en    <= 1'b0;
            strobe_bus_out <= 1'b0;
        end else begin
            pad_out        <= {dly_out[1], pout_pre[0]};
            pad_oe         <= dly_out[4];
            pad_term_en    <= dly_out[6];
            strobe_bus_out <= dly_out[8];
        end
    end

    // write clocks: quarter-phase counter gives 90 degree offset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wph_r    <= 2'h0;
            wclk_dqs <= 1'b0;
            wclk_dq  <= 1'b0;
        end else begin
            wph_r    <= wph_r + 2'h1;
            // leveling source shifts both clocks by one extra step
            if (ctrl_r[ddrp_pkg::WCLK_SRC_BIT]) begin
                wclk_dqs <= wph_r[1] ^ wph_r[0];
                wclk_dq  <= ~wph_r[1];
            end else begin
                wclk_dqs <= wph_r[1];
                wclk_dq  <= wph_r[1] ^ wph_r[0];
            end
        end
    end

endmodule

`default_nettype wire

/* File: ddrp_io_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// watches apb answers, reset state and write clocks at the pins
module ddrp_io_monitor (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  pad_out,
    input wire logic        pad_oe,
    input wire logic        wclk_dq,
    input wire logic        wclk_dqs
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdy_late_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    bad_addr_a: assert property (psel && penable && !pready &&
        !(paddr inside {8'h00, 8'h04, 8'h08}) |=> pslverr) else $error("no error");
    good_addr_a: assert property (psel && penable && !pready &&
        (paddr inside {8'h00, 8'h04, 8'h08}) |=> !pslverr) else $error("false error");
    idle_bus_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("answer outside pready");
    reset_pins_a: assert property ($rose(rstn) |-> pad_out == 2'h0 && !pad_oe)
        else $error("pins not low after reset");
    wclk_period_a: assert property ($rose(wclk_dqs) |=> wclk_dqs ##1 !wclk_dqs[*2]
        ##1 wclk_dqs) else $error("write clock period wrong");
    wclk_offset_a: assert property ($rose(wclk_dqs) |-> !$changed(wclk_dq)
        ##1 $changed(wclk_dq)) else $error("write clocks not a quarter apart");
endmodule
bind ddrp_io_datapath ddrp_io_monitor i_mon (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_out(pad_out), .pad_oe(pad_oe), .wclk_dq(wclk_dq), .wclk_dqs(wclk_dqs));
`default_nettype wire

/* File: ddrp_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// far-side memory: read strobe, echo clock, data line, write capture
module ddrp_mem_model (
    input  wire logic       ref_clk,
    input  wire logic       rd_en,
    input  wire logic       rd_bit,
    input  wire logic       pad_oe,
    input  wire logic [1:0] pad_out,
    output logic            pad_in,
    output logic            strobe_in,
    output logic            echo_in,
    output logic [1:0]      last_wr
);
    logic tog_r;  // pattern for a released data line
    // known start values
    initial begin
        strobe_in = 1'b0;
        tog_r = 1'b0;
        last_wr = 2'h0;
    end
    // strobe runs only within a read burst, idle low otherwise
    always @(posedge ref_clk) begin
        strobe_in <= rd_en ? ~strobe_in : 1'b0;
        tog_r <= ~tog_r;
        if (pad_oe) begin
            last_wr <= pad_out;
        end
    end
    // echo clock is the strobe complement, strobe sent uninverted
    assign echo_in = rd_en & ~strobe_in;
    // a released data line never holds its last bit
    assign pad_in = rd_en ? rd_bit : tog_r;
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the io register datapath
module tb;
    logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err, rd_en, rd_bit;
    logic        pad_in, strobe_in, echo_in, postamble_en, chain_in, chain_out, core_term_en;
    logic        pad_oe, pad_term_en, strobe_bus_out, wclk_dq, wclk_dqs;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  core_rd_data, core_wr_data;
    logic [1:0]  core_oe, pad_out, last_wr;
    logic [87:0] tab[10];  // ctrl, delay, read/write/enable latency
    int          error_cnt, num_checks, cyc, lr, lw, lo;
    ddrp_io_datapath i_ddrp_io_datapath (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pad_in, .strobe_in, .echo_in,
        .global_clk_in(strobe_in), .postamble_en, .chain_in, .chain_out, .core_rd_data,
        .core_wr_data, .core_oe, .core_term_en, .pad_out, .pad_oe, .pad_term_en,
        .strobe_bus_out, .wclk_dq, .wclk_dqs);
    ddrp_mem_model i_ddrp_mem_model (.ref_clk, .rd_en, .rd_bit, .pad_oe, .pad_out, .pad_in,
        .strobe_in, .echo_in, .last_wr);
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // compare and count
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // set mode, flush, then step read, write and enable inputs and time those three paths
    task meas(input logic [31:0] c, input logic [31:0] d);
        apb(1'b1, 8'h00, c);
        apb(1'b1, 8'h04, d);
        rd_bit <= 1'b0;
        core_wr_data <= 4'h0;
        core_oe <= 2'h0;
        repeat (12) @(posedge ref_clk);
        rd_bit <= 1'b1;
        core_wr_data <= 4'hA;
        core_oe <= 2'h3;
        lr = 0;
        lw = 0;
        lo = 0;
        for (int i = 1; i < 16; i++) begin
            @(posedge ref_clk);
            #1;
            if (lr == 0 && core_rd_data === 4'hF) lr = i;
            if (lw == 0 && pad_out === 2'h2) lw = i;
            if (lo == 0 && pad_oe === 1'b1) lo = i;
        end
        @(posedge ref_clk);
    endtask
    // verdict
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rd_bit, postamble_en, chain_in} = '0;
        {core_term_en, core_wr_data, core_oe, rstn, error_cnt, num_checks, cyc} = '0;
        rd_en = 1'b1;
        tab = '{{32'h1F07, 32'h0, 8'h01, 8'h01, 8'h01},
                {32'h1F45, 32'h0, 8'h02, 8'h01, 8'h01},
                {32'h1F85, 32'h0, 8'h03, 8'h01, 8'h01},
                {32'h1FC5, 32'h0, 8'h04, 8'h01, 8'h01},
                {32'h1D07, 32'h0, 8'h02, 8'h01, 8'h01},
                {32'h1707, 32'h0, 8'h01, 8'h02, 8'h02},
                {32'h9F07, 32'h0, 8'h01, 8'h02, 8'h02},
                {32'h0F07, 32'h0, 8'h01, 8'h01, 8'h02},
                {32'h1B07, 32'h0, 8'h01, 8'h02, 8'h02},
                {32'h1F07, 32'h1C0, 8'h08, 8'h01, 8'h01}};
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", rd, ddrp_pkg::CTRL_RST);
        apb(1'b0, 8'h04, 32'h0);
        chk("delay reset", rd, ddrp_pkg::DELAY_RST);
        apb(1'b1, 8'h04, 32'h1C0);
        apb(1'b0, 8'h04, 32'h0);
        chk("delay readback", rd, 32'h1C0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        $display("test registers done");
        for (int k = 0; k < 10; k++) begin
            meas(tab[k][87:56], tab[k][55:24]);
            chk("read latency", lr, {24'h0, tab[k][23:16]});
            chk("write latency", lw, {24'h0, tab[k][15:8]});
            chk("enable latency", lo, {24'h0, tab[k][7:0]});
        end
        chk("memory write", {30'h0, last_wr}, 32'h2);
        $display("test latencies done");
        postamble_en <= 1'b1;
        // gated, plain strobe, global line, then strobe with echo clock
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h00, k < 3 ? 32'h1F06 | (k << 4) : 32'h1F1E);
            rd_bit <= ~k[0];
            repeat (10) @(posedge ref_clk);
            apb(1'b0, 8'h08, 32'h0);
            chk("capture state", {28'h0, rd[3:0]}, {28'h0, {4{~k[0]}}});
        end
        // gated source with postamble low: no capture edges reach the pair
        postamble_en <= 1'b0;
        apb(1'b1, 8'h00, 32'h1F06);
        rd_bit <= 1'b1;
        repeat (10) @(posedge ref_clk);
        apb(1'b0, 8'h08, 32'h0);
        chk("capture gated", {28'h0, rd[3:0]}, 32'h0);
        $display("test capture done");
        // chained divider, termination chains 1+2, strobe bus chain 1
        apb(1'b1, 8'h00, 32'h21F07);
        apb(1'b1, 8'h04, 32'h0108_8000);
        chain_in <= 1'b1;
        core_term_en <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("term early", {31'h0, pad_term_en}, 32'h0);
        @(posedge ref_clk);
        #1;
        chk("term delay", {31'h0, pad_term_en}, 32'h1);
        chk("chain follow", {31'h0, chain_out}, 32'h0);
        chk("strobe bus", {31'h0, strobe_bus_out}, {31'h0, strobe_in});
        $display("test chains done");
        end_of_test();
    end
endmodule
`default_nettype wire
